// ==== src/redriver_regs.vh ====
`ifndef REDRIVER_REGS_VH
`define REDRIVER_REGS_VH

// ==========================================================
// Channel register offsets
`define OFF_DET_STATUS 5'h00
`define OFF_EQ_BOOST 5'h01
`define OFF_PROFILE_GAIN 5'h03
`define OFF_DET_CTRL 5'h04
`define OFF_PD_OVR 5'h05
`define OFF_DET_RESTART 5'h0a

// ==========================================================
// Channel base decode (pointer bits 7:5)
`define BASE_CH0_A 3'h0
`define BASE_CH0_B 3'h1
`define BASE_CH1_A 3'h2
`define BASE_CH1_B 3'h3
`define BASE_BCAST 3'h4

// ==========================================================
// Shared general register and its self-clearing reset bit
`define OFF_SHARED_GEN 8'he2
`define BIT_SOFT_RESET 6

// ==========================================================
// Field positions
`define BIT_DET_P 7
`define BIT_DET_N 6
`define BIT_STAGE1_SKIP 7
`define BIT_FORCE_VALID 2
`define BIT_POLL_EXTRA 1
`define BIT_POLL_THREE 0
`define BIT_OVR_EN 7
`define BIT_FSM_RESTART 2

// ==========================================================
// Reset values and writable masks
`define RST_EQ_BOOST 8'h00
`define RST_PROFILE_GAIN 8'h05
`define RST_DET_CTRL 8'h00
`define RST_PD_OVR 8'h7f
`define RST_DET_RESTART 8'h00
`define MASK_PROFILE_GAIN 8'h7f
`define MASK_DET_CTRL 8'h07
`define MASK_DET_RESTART 8'h04

// ==========================================================
// Timing
// Poll interval of 150 us counted in 25 ns clocks
`define POLL_CYCLES_DEF 16'h1770
`define POLLS_BASE 2'h1
`define POLLS_TWO 2'h2
`define POLLS_THREE 2'h3

`endif

// ==== src/chan_regs.v ====
`include "redriver_regs.vh"

module chan_regs (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  input wire softRst,
  // Write port
  input wire wrEn,
  input wire [4:0] wrOff,
  input wire [7:0] wrData,
  // Read port
  input wire [4:0] rdOff,
  output reg [7:0] rdData,
  // Latched detect status
  input wire statP,
  input wire statN,
  // Register contents
  output reg [7:0] eqReg_r,
  output reg [7:0] profReg_r,
  output reg [7:0] detCtl_r,
  output reg [7:0] pdReg_r,
  output reg [7:0] rstReg_r
);

  // ========================================================
  // Storage; reserved bits are masked off on write
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eqReg_r <= `RST_EQ_BOOST;
      profReg_r <= `RST_PROFILE_GAIN;
      detCtl_r <= `RST_DET_CTRL;
      pdReg_r <= `RST_PD_OVR;
      rstReg_r <= `RST_DET_RESTART;
    end else if (softRst) begin
      eqReg_r <= `RST_EQ_BOOST;
      profReg_r <= `RST_PROFILE_GAIN;
      detCtl_r <= `RST_DET_CTRL;
      pdReg_r <= `RST_PD_OVR;
      rstReg_r <= `RST_DET_RESTART;
    end else if (wrEn) begin
      case (wrOff)
        `OFF_EQ_BOOST: eqReg_r <= wrData;
        `OFF_PROFILE_GAIN: profReg_r <= wrData & `MASK_PROFILE_GAIN;
        `OFF_DET_CTRL: detCtl_r <= wrData & `MASK_DET_CTRL;
        `OFF_PD_OVR: pdReg_r <= wrData;
        `OFF_DET_RESTART: rstReg_r <= wrData & `MASK_DET_RESTART;
        default: eqReg_r <= eqReg_r;
      endcase
    end
  end

  // ========================================================
  // Read mux
  always @* begin
    case (rdOff)
      `OFF_DET_STATUS: rdData = {statP, statN, 6'h00};
      `OFF_EQ_BOOST: rdData = eqReg_r;
      `OFF_PROFILE_GAIN: rdData = profReg_r;
      `OFF_DET_CTRL: rdData = detCtl_r;
      `OFF_PD_OVR: rdData = pdReg_r;
      `OFF_DET_RESTART: rdData = rstReg_r;
      default: rdData = 8'h00;
    endcase
  end

endmodule // chan_regs

// ==== src/term_detect_fsm.v ====
`include "redriver_regs.vh"

module term_detect_fsm #(
  parameter [15:0] POLL_CYCLES = 16'h1770
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Comparator results, already synchronised
  input wire compP,
  input wire compN,
  // Controls
  input wire forceValid,
  input wire pollExtra,
  input wire pollThree,
  input wire restart,
  input wire standby,
  // Results
  output reg statP_r,
  output reg statN_r,
  output reg termValid_r,
  output reg detPulse_r
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_CHECK = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  reg [1:0] st_r;
  reg [15:0] timer_r;
  reg [1:0] hits_r;
  wire [1:0] need;
  wire hold;

  // Number of consecutive valid polls needed
  assign need = !pollExtra ? `POLLS_BASE :
    (pollThree ? `POLLS_THREE : `POLLS_TWO);
  assign hold = restart | standby;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
      timer_r <= 16'h0000;
      hits_r <= 2'h0;
      statP_r <= 1'b0;
      statN_r <= 1'b0;
      termValid_r <= 1'b0;
      detPulse_r <= 1'b0;
    end else if (hold) begin
      st_r <= ST_IDLE;
      hits_r <= 2'h0;
      statP_r <= 1'b0;
      statN_r <= 1'b0;
      // Force still applies while the machine is held
      termValid_r <= forceValid;
      detPulse_r <= 1'b0;
    end else begin
      detPulse_r <= 1'b0;
      termValid_r <= forceValid | (st_r == ST_DONE);
      case (st_r)
        ST_IDLE: begin
          timer_r <= POLL_CYCLES;
          st_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (timer_r == 16'h0000) begin
            detPulse_r <= 1'b1;
            st_r <= ST_CHECK;
          end else begin
            timer_r <= timer_r - 16'h0001;
          end
        end
        ST_CHECK: begin
          // Detected levels stay latched until a restart or standby
          if (compP) statP_r <= 1'b1;
          if (compN) statN_r <= 1'b1;
          timer_r <= POLL_CYCLES;
          if (compP && compN) begin
            if (hits_r + 2'h1 >= need) begin
              st_r <= ST_DONE;
            end else begin
              hits_r <= hits_r + 2'h1;
              st_r <= ST_WAIT;
            end
          end else begin
            hits_r <= 2'h0;
            st_r <= ST_WAIT;
          end
        end
        ST_DONE: st_r <= ST_DONE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

endmodule // term_detect_fsm

// ==== src/redriver_channel_config_regs.v ====
// Functional notes
// - Status bit 7 shows positive-pin termination detect, latched once seen.
// - Status bit 6 shows negative-pin termination detect, latched the same way.
// - Boost register bit 7 skips the first equalizer stage when 1, reset 0.
// - Boost register holds stage-one code in 6:3 and stage-two code in 2:0.
// - Offset 3 holds the midband shape code in 6:3, bit 7 reads zero.
// - Offset 3 bits 2:0 hold the flat gain code, reset value 3'b101.
// - Offset 4 bit 2 forces termination valid regardless of the detect FSM.
// - Offset 4 bit 1 enables extra detect polling, reset disabled.
// - Offset 4 bit 0 picks two or three valid polls, only with bit 1 set.
// - Offset 5 bit 7 lets the enable field drive the block enables.
// - Offset 5 low field enables blocks one by one while overridden.
// - Offset 0x0a bit 2 holds the detect FSM in reset while set.
// - Channel 0 sits at 0x00/0x20, channel 1 at 0x40/0x60, 0x80 broadcasts.
// - Registers are reached as a serial-bus secondary at a strapped address.
`include "redriver_regs.vh"

module redriver_channel_config_regs #(
  parameter [15:0] POLL_CYCLES = `POLL_CYCLES_DEF
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Serial bus pins
  input wire scl,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  // Strapped secondary address
  input wire [6:0] busAddr,
  // Device pins
  input wire standby_pin,
  input wire [1:0] rxCompP,
  input wire [1:0] rxCompN,
  // Analog controls, two channels packed
  output wire [1:0] first_stage_skip,
  output wire [7:0] first_stage_boost_code,
  output wire [5:0] second_stage_boost_code,
  output wire [7:0] midband_boost_shape,
  output wire [5:0] flatGainSel,
  output reg [13:0] blockEnable,
  output wire [1:0] termValid,
  output wire [1:0] detectPulse
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_AACK = 4'h2;
  localparam [3:0] ST_PTR = 4'h3;
  localparam [3:0] ST_WACK = 4'h4;
  localparam [3:0] ST_WR = 4'h5;
  localparam [3:0] ST_RD = 4'h6;
  localparam [3:0] ST_RACK = 4'h7;

  // ========================================================
  // Channel selection from a register pointer
  function [1:0] chanMask;
    input [7:0] ptr;
    begin
      case (ptr[7:5])
        `BASE_CH0_A, `BASE_CH0_B: chanMask = 2'b01;
        `BASE_CH1_A, `BASE_CH1_B: chanMask = 2'b10;
        `BASE_BCAST: chanMask = 2'b11;
        default: chanMask = 2'b00;
      endcase
    end
  endfunction

  // ========================================================
  // Pin synchronisers
  reg [13:0] syncA_r;
  reg [13:0] syncB_r;
  wire sclS;
  wire sdaS;
  wire standbyS;
  wire [1:0] compPS;
  wire [1:0] compNS;
  wire [6:0] addrS;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_r <= 14'h0003;
      syncB_r <= 14'h0003;
    end else begin
      syncA_r <= {busAddr, rxCompN, rxCompP, standby_pin, sdaIn, scl};
      syncB_r <= syncA_r;
    end
  end

  assign sclS = syncB_r[0];
  assign sdaS = syncB_r[1];
  assign standbyS = syncB_r[2];
  assign compPS = syncB_r[4:3];
  assign compNS = syncB_r[6:5];
  assign addrS = syncB_r[13:7];

  // ========================================================
  // Bus edge and condition detection
  reg sclD_r;
  reg sdaD_r;
  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclD_r <= sclS;
      sdaD_r <= sdaS;
    end
  end

  assign sclRise = sclS & ~sclD_r;
  assign sclFall = ~sclS & sclD_r;
  assign startCond = sclS & sclD_r & sdaD_r & ~sdaS;
  assign stopCond = sclS & sclD_r & ~sdaD_r & sdaS;

  // ========================================================
  // Secondary state machine
  reg [3:0] st_r;
  reg [2:0] bitCnt_r;
  reg full_r;
  reg [7:0] shift_r;
  reg [7:0] ptr_r;
  reg rw_r;
  reg ack_r;
  reg [1:0] wrEn_r;
  reg softRst_r;
  reg [7:0] wrData_r;
  reg [4:0] wrOff_r;
  wire [7:0] rdData;
  wire [7:0] rd0;
  wire [7:0] rd1;
  wire [1:0] rdMask;

  assign rdMask = chanMask(ptr_r);
  assign rdData = rdMask[0] ? rd0 : (rdMask[1] ? rd1 : 8'h00);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
      bitCnt_r <= 3'h0;
      full_r <= 1'b0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      ack_r <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      wrEn_r <= 2'b00;
      softRst_r <= 1'b0;
      wrData_r <= 8'h00;
      wrOff_r <= 5'h00;
    end else begin
      wrEn_r <= 2'b00;
      softRst_r <= 1'b0;
      sdaOut <= 1'b0;
      if (startCond) begin
        st_r <= ST_ADDR;
        bitCnt_r <= 3'h0;
        full_r <= 1'b0;
        sdaOe <= 1'b0;
      end else if (stopCond) begin
        st_r <= ST_IDLE;
        sdaOe <= 1'b0;
      end else if (sclRise) begin
        if (st_r == ST_RACK) begin
          ack_r <= ~sdaS;
        end else if (st_r == ST_ADDR || st_r == ST_PTR ||
                     st_r == ST_WR || st_r == ST_RD) begin
          shift_r <= {shift_r[6:0], sdaS};
          bitCnt_r <= bitCnt_r + 3'h1;
          full_r <= (bitCnt_r == 3'h7);
        end
      end else if (sclFall) begin
        case (st_r)
          ST_ADDR: begin
            if (full_r) begin
              full_r <= 1'b0;
              if (shift_r[7:1] == addrS) begin
                rw_r <= shift_r[0];
                sdaOe <= 1'b1;
                st_r <= ST_AACK;
              end else begin
                st_r <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bitCnt_r <= 3'h0;
            if (rw_r) begin
              shift_r <= rdData;
              sdaOe <= ~rdData[7];
              ptr_r <= ptr_r + 8'h01;
              st_r <= ST_RD;
            end else begin
              sdaOe <= 1'b0;
              st_r <= ST_PTR;
            end
          end
          ST_PTR: begin
            if (full_r) begin
              full_r <= 1'b0;
              ptr_r <= shift_r;
              sdaOe <= 1'b1;
              st_r <= ST_WACK;
            end
          end
          ST_WACK: begin
            sdaOe <= 1'b0;
            bitCnt_r <= 3'h0;
            st_r <= ST_WR;
          end
          ST_WR: begin
            if (full_r) begin
              full_r <= 1'b0;
              wrData_r <= shift_r;
              wrOff_r <= ptr_r[4:0];
              wrEn_r <= chanMask(ptr_r);
              softRst_r <= (ptr_r == `OFF_SHARED_GEN) &
                shift_r[`BIT_SOFT_RESET];
              ptr_r <= ptr_r + 8'h01;
              sdaOe <= 1'b1;
              st_r <= ST_WACK;
            end
          end
          ST_RD: begin
            if (full_r) begin
              full_r <= 1'b0;
              sdaOe <= 1'b0;
              st_r <= ST_RACK;
            end else begin
              sdaOe <= ~shift_r[7];
            end
          end
          ST_RACK: begin
            bitCnt_r <= 3'h0;
            if (ack_r) begin
              shift_r <= rdData;
              sdaOe <= ~rdData[7];
              ptr_r <= ptr_r + 8'h01;
              st_r <= ST_RD;
            end else begin
              st_r <= ST_IDLE;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ========================================================
  // Channels
  wire [15:0] rdAll;
  wire [15:0] pdAll;

  assign rd0 = rdAll[7:0];
  assign rd1 = rdAll[15:8];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      wire [7:0] eqReg;
      wire [7:0] profReg;
      wire [7:0] detCtl;
      wire [7:0] pdReg;
      wire [7:0] rstReg;
      wire statP;
      wire statN;

      chan_regs u_regs (
        .clk(clk),
        .rst_b(rst_b),
        .softRst(softRst_r),
        .wrEn(wrEn_r[ch]),
        .wrOff(wrOff_r),
        .wrData(wrData_r),
        .rdOff(ptr_r[4:0]),
        .rdData(rdAll[ch*8 +: 8]),
        .statP(statP),
        .statN(statN),
        .eqReg_r(eqReg),
        .profReg_r(profReg),
        .detCtl_r(detCtl),
        .pdReg_r(pdReg),
        .rstReg_r(rstReg)
      );

      term_detect_fsm #(
        .POLL_CYCLES(POLL_CYCLES)
      ) u_det (
        .clk(clk),
        .rst_b(rst_b),
        .compP(compPS[ch]),
        .compN(compNS[ch]),
        .forceValid(detCtl[`BIT_FORCE_VALID]),
        .pollExtra(detCtl[`BIT_POLL_EXTRA]),
        .pollThree(detCtl[`BIT_POLL_THREE]),
        .restart(rstReg[`BIT_FSM_RESTART]),
        .standby(standbyS),
        .statP_r(statP),
        .statN_r(statN),
        .termValid_r(termValid[ch]),
        .detPulse_r(detectPulse[ch])
      );

      assign first_stage_skip[ch] = eqReg[`BIT_STAGE1_SKIP];
      assign first_stage_boost_code[ch*4 +: 4] = eqReg[6:3];
      assign second_stage_boost_code[ch*3 +: 3] = eqReg[2:0];
      assign midband_boost_shape[ch*4 +: 4] = profReg[6:3];
      assign flatGainSel[ch*3 +: 3] = profReg[2:0];
      // Field is honoured only while the override bit is set
      assign pdAll[ch*8 +: 8] = pdReg[`BIT_OVR_EN] ?
        {1'b0, pdReg[6:0]} : 8'h7f;
    end
  endgenerate

  // ========================================================
  // Block enables, all off in standby
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blockEnable <= 14'h0000;
    end else if (standbyS) begin
      blockEnable <= 14'h0000;
    end else begin
      blockEnable <= {pdAll[14:8], pdAll[6:0]};
    end
  end

endmodule // redriver_channel_config_regs

// ==== verif/redriver_channel_config_regs_properties.sv ====
module redriver_channel_config_regs_properties #(
  parameter [15:0] POLL_CYCLES = 16'h1770
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Serial bus
  input wire scl,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe,
  input wire [6:0] busAddr,
  // Device pins
  input wire standby_pin,
  input wire [1:0] rxCompP,
  input wire [1:0] rxCompN,
  // Analog controls
  input wire [1:0] first_stage_skip,
  input wire [7:0] first_stage_boost_code,
  input wire [5:0] second_stage_boost_code,
  input wire [7:0] midband_boost_shape,
  input wire [5:0] flatGainSel,
  input wire [13:0] blockEnable,
  input wire [1:0] termValid,
  input wire [1:0] detectPulse
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclPrev_r;
  logic [7:0] sinceFall_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // Cycles since the last bus clock fall
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev_r <= 1'b1;
      sinceFall_r <= 8'hff;
    end else begin
      sclPrev_r <= scl;
      if (sclPrev_r && !scl) begin
        sinceFall_r <= 8'h00;
      end else if (sinceFall_r != 8'hff) begin
        sinceFall_r <= sinceFall_r + 8'h01;
      end
    end
  end

  // ==========================================================
  // Checks
  reset_flat_gain_a: assert property (
    $rose(rst_b) |-> flatGainSel == 6'h2d) else $error("flat gain default");
  skip_reset_zero_a: assert property (
    $rose(rst_b) |-> first_stage_skip == 2'h0) else $error("skip default");
  boost_reset_zero_a: assert property (
    $rose(rst_b) |-> {first_stage_boost_code, second_stage_boost_code}
    == 14'h0) else $error("boost default");
  term_reset_low_a: assert property (
    $rose(rst_b) |-> termValid == 2'h0) else $error("termValid default");
  enable_after_reset_a: assert property (
    $rose(rst_b) && !standby_pin |=> blockEnable == 14'h3fff)
    else $error("blocks not enabled");
  standby_blocks_off_a: assert property (
    standby_pin [*4] |=> blockEnable == 14'h0) else $error("standby");
  poll_gap_a: assert property (
    detectPulse[0] |=> !detectPulse[0] [*8]) else $error("poll gap");
  cfg_on_bus_a: assert property (
    !$stable({first_stage_skip, first_stage_boost_code,
    second_stage_boost_code, midband_boost_shape, flatGainSel})
    |-> sinceFall_r <= 8'h0a) else $error("config changed off bus");
  sda_scl_low_a: assert property (
    $changed(sdaOe) |-> !scl && sinceFall_r < 8'h08)
    else $error("sda moved with scl high");
  cover property ($rose(termValid[1]));
  cover property ($rose(sdaOe));
  cover property ($fell(blockEnable[0]));
endmodule // redriver_channel_config_regs_properties

bind redriver_channel_config_regs redriver_channel_config_regs_properties #(
  .POLL_CYCLES(POLL_CYCLES)
) props (
  .clk(clk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .busAddr(busAddr), .standby_pin(standby_pin),
  .rxCompP(rxCompP), .rxCompN(rxCompN), .first_stage_skip(first_stage_skip),
  .first_stage_boost_code(first_stage_boost_code),
  .second_stage_boost_code(second_stage_boost_code),
  .midband_boost_shape(midband_boost_shape), .flatGainSel(flatGainSel),
  .blockEnable(blockEnable), .termValid(termValid),
  .detectPulse(detectPulse)
);

// ==== verif/i2c_host_model.sv ====
module i2c_host_model (
  // Clock
  input wire logic clk,
  // Bus lines, sdaLow pulls the data line down
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Bit level, quarter period of 25 clocks gives 400 kHz
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick();
    repeat (25) @(negedge clk);
  endtask
  task automatic startCond();
    sdaLow = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sdaLow = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask
  task automatic stopCond();
    sdaLow = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sdaLow = 1'b0;
    tick();
  endtask
  task automatic putBit(input logic b);
    sdaLow = ~b;
    tick();
    scl = 1'b1;
    tick();
    tick();
    scl = 1'b0;
    tick();
  endtask
  task automatic getBit(output logic b);
    sdaLow = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    b = sda;
    tick();
    scl = 1'b0;
    tick();
  endtask

  // ==========================================================
  // Byte level and transfers, MSB first
  task automatic putByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) putBit(d[i]);
    getBit(b);
    ack = ~b;
  endtask
  task automatic getByte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) getBit(d[i]);
    putBit(last);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input int n,
                    input logic [47:0] d, output logic ack);
    logic x;
    startCond();
    putByte({a, 1'b0}, ack);
    putByte(p, x);
    for (int i = n - 1; i >= 0; i--) putByte(d[8*i +: 8], x);
    stopCond();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n,
                    output logic [47:0] d);
    logic [7:0] b;
    logic x;
    d = 48'h0;
    startCond();
    putByte({a, 1'b0}, x);
    putByte(p, x);
    startCond();
    putByte({a, 1'b1}, x);
    for (int i = n - 1; i >= 0; i--) begin
      getByte(b, i == 0);
      d = {d[39:0], b};
    end
    stopCond();
  endtask
endmodule // i2c_host_model

// ==== verif/redriver_channel_config_regs_tb.sv ====
module redriver_channel_config_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADDR = 7'h1c;
  logic clk, rst_b, standby_pin, ack;
  logic [1:0] rxCompP, rxCompN;
  logic [47:0] got;
  wire logic scl, sdaLow, sda, sdaOut, sdaOe;
  wire logic [1:0] first_stage_skip, termValid, detectPulse;
  wire logic [7:0] first_stage_boost_code, midband_boost_shape;
  wire logic [5:0] second_stage_boost_code, flatGainSel;
  wire logic [13:0] blockEnable;
  int miscompares, checkCount, pulses;

  // ==========================================================
  // Design, host and open-drain data line with pull-up
  assign sda = !(sdaLow || (sdaOe && !sdaOut));
  redriver_channel_config_regs #(.POLL_CYCLES(16'h0008)) uut (
    .clk(clk), .rst_b(rst_b), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .busAddr(ADDR), .standby_pin(standby_pin),
    .rxCompP(rxCompP), .rxCompN(rxCompN),
    .first_stage_skip(first_stage_skip),
    .first_stage_boost_code(first_stage_boost_code),
    .second_stage_boost_code(second_stage_boost_code),
    .midband_boost_shape(midband_boost_shape), .flatGainSel(flatGainSel),
    .blockEnable(blockEnable), .termValid(termValid),
    .detectPulse(detectPulse)
  );
  i2c_host_model host (.clk(clk), .scl(scl), .sdaLow(sdaLow), .sda(sda));
  always #12.5 clk = ~clk;
  always @(negedge clk) begin
    if (detectPulse[1] === 1'b1 && termValid[1] !== 1'b1) pulses++;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    checkCount++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && checkCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wrReg(input logic [7:0] p, input int n,
                       input logic [47:0] d);
    host.wr(ADDR, p, n, d, ack);
    chk("ack", 48'h1, {47'h0, ack});
  endtask
  task automatic rdChk(input logic [7:0] p, input int n,
                       input logic [47:0] e, input string nm);
    host.rd(ADDR, p, n, got);
    chk(nm, e, got);
  endtask

  // ==========================================================
  // Scenarios
  task automatic resetDefaults();
    rdChk(8'h00, 6, 48'h0000_0005_007f, "regs00to05");
    rdChk(8'h0a, 1, 48'h0, "restartReg");
    chk("blockEnable", 48'h3fff, {34'h0, blockEnable});
  endtask
  task automatic fieldWrites();
    wrReg(8'h21, 5, 48'hff_ffff_f883);
    chk("ch0Fields", {15'h7fff, 14'h3f83}, {first_stage_skip[0],
      first_stage_boost_code[3:0], second_stage_boost_code[2:0],
      midband_boost_shape[3:0], flatGainSel[2:0], blockEnable});
    rdChk(8'h20, 6, 48'h00ff_007f_0083, "regs20to25");
    wrReg(8'h85, 1, 48'h80);
    chk("blockEnable", 48'h0, {34'h0, blockEnable});
    rdChk(8'h45, 1, 48'h80, "ch1Override");
    wrReg(8'h85, 1, 48'h00);
    chk("blockEnable", 48'h3fff, {34'h0, blockEnable});
    host.wr(7'h1d, 8'h01, 1, 48'h0, ack);
    chk("badAddrAck", 48'h0, {47'h0, ack});
    wrReg(8'h00, 1, 48'hff);
    rdChk(8'h00, 2, 48'h00ff, "statusAndBoost");
  endtask
  task automatic latchStatus();
    rxCompP = 2'b01;
    repeat (40) @(negedge clk);
    rxCompP = 2'b00;
    rdChk(8'h00, 1, 48'h80, "statusP");
    rxCompN = 2'b01;
    repeat (40) @(negedge clk);
    rxCompN = 2'b00;
    rdChk(8'h00, 1, 48'hc0, "statusPN");
    wrReg(8'h0a, 1, 48'h04);
    rdChk(8'h00, 1, 48'h00, "statusCleared");
    wrReg(8'h04, 1, 48'h04);
    chk("forced", 48'h1, {47'h0, termValid[0]});
    wrReg(8'h04, 1, 48'h00);
    chk("unforced", 48'h0, {47'h0, termValid[0]});
    wrReg(8'h0a, 1, 48'h00);
  endtask
  task automatic pollCounts();
    standby_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk("standby", 48'h0, {34'h0, blockEnable});
    standby_pin = 1'b0;
    rxCompP = 2'b10;
    rxCompN = 2'b10;
    wrReg(8'h4a, 1, 48'h04);
    for (int k = 1; k <= 3; k++) begin
      wrReg(8'h44, 1, (k == 1) ? 48'h01 : 48'(k));
      pulses = 0;
      wrReg(8'h4a, 1, 48'h00);
      for (int i = 0; i < 400 && termValid[1] !== 1'b1; i++) @(negedge clk);
      if (termValid[1] !== 1'b1) begin
        chk("termWait", 48'h1, {47'h0, termValid[1]});
        report_and_stop();
      end
      chk("polls", 48'(k), 48'(pulses));
      if (k < 3) wrReg(8'h4a, 1, 48'h04);
    end
    // Shared soft reset brings every channel field but the latched detect status back to default
    wrReg(8'he2, 1, 48'h40);
    chk("softReset", 48'h2d, {18'h0, first_stage_skip,
      first_stage_boost_code, second_stage_boost_code,
      midband_boost_shape, flatGainSel});
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    standby_pin = 1'b0;
    rxCompP = 2'b00;
    rxCompN = 2'b00;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    resetDefaults();
    fieldWrites();
    latchStatus();
    pollCounts();
    report_and_stop();
  end
endmodule // redriver_channel_config_regs_tb
